// File: verilog/bmw_window_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bmw_window_decode
    import bmw_pkg::*;
#(
    parameter logic [11:0] PF_LOW_RST = 12'h000
) (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // configuration access
    input wire logic i_cfg_sel,
    input wire logic i_cfg_we,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [3:0] i_cfg_be,
    input wire logic [31:0] i_cfg_wdata,
    output logic o_cfg_ack,
    output logic [31:0] o_cfg_rdata,
    // prefetchable upper halves from their own registers
    input wire logic [31:0] i_pf_low_upper,
    input wire logic [31:0] i_pf_high_upper,
    // transaction to decode
    input wire bmw_txn_t i_txn,
    output bmw_result_t o_result,
    // live window view
    output logic [11:0] o_np_window_low_field,
    output logic [11:0] o_np_window_high_field,
    output logic [11:0] o_pf_window_low_field,
    output logic [11:0] o_pf_window_high_field
);

    // ============================================================
    // helpers
    // merge one 16-bit register half, keeping only the 12-bit field
    function automatic logic [11:0] merge_field(
        input logic [11:0] old_field,
        input logic [15:0] wdata,
        input logic [1:0] be
    );
        logic [15:0] cur;
        cur = {old_field, 4'h0};
        if (be[0]) begin
            cur[7:0] = wdata[7:0];
        end
        if (be[1]) begin
            cur[15:8] = wdata[15:8];
        end
        return cur[BMW_FIELD_LSB +: BMW_FIELD_W];
    endfunction : merge_field

    // widen a 12-bit field and upper half into a full window bound
    function automatic logic [63:0] make_bound(
        input logic [31:0] upper,
        input logic [11:0] field,
        input logic [19:0] fill
    );
        return {upper, field, fill};
    endfunction : make_bound

    // ============================================================
    // storage
    logic [11:0] np_low_q;
    logic [11:0] np_high_q;
    logic [11:0] pf_low_q;
    logic [11:0] pf_high_q;
    logic wr_np;
    logic wr_pf;
    logic [15:0] wlo;
    logic [15:0] whi;
    logic [1:0] be_lo;
    logic [1:0] be_hi;

    assign wr_np = i_cfg_sel && i_cfg_we && (i_cfg_addr == BMW_OFF_NP_DWORD);
    assign wr_pf = i_cfg_sel && i_cfg_we && (i_cfg_addr == BMW_OFF_PF_DWORD);
    assign wlo = i_cfg_wdata[BMW_HALF_W-1:0];
    assign whi = i_cfg_wdata[2*BMW_HALF_W-1:BMW_HALF_W];
    assign be_lo = i_cfg_be[1:0];
    assign be_hi = i_cfg_be[3:BMW_TOP_LANE];

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            np_low_q <= BMW_FIELD_RST;
        end else if (wr_np) begin
            np_low_q <= merge_field(np_low_q, wlo, be_lo);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            np_high_q <= BMW_FIELD_RST;
        end else if (wr_np) begin
            np_high_q <= merge_field(np_high_q, whi, be_hi);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pf_low_q <= PF_LOW_RST;
        end else if (wr_pf) begin
            pf_low_q <= merge_field(pf_low_q, wlo, be_lo);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pf_high_q <= BMW_FIELD_RST;
        end else if (wr_pf) begin
            pf_high_q <= merge_field(pf_high_q, whi, be_hi);
        end
    end

    assign o_np_window_low_field = np_low_q;
    assign o_np_window_high_field = np_high_q;
    assign o_pf_window_low_field = pf_low_q;
    assign o_pf_window_high_field = pf_high_q;

    // ============================================================
    // read path
    logic [31:0] rdata_d;

    always_comb begin
        rdata_d = BMW_UNMAPPED_DATA;
        case (i_cfg_addr)
            BMW_OFF_NP_DWORD: begin
                rdata_d = {np_high_q, BMW_NP_RSVD, np_low_q, BMW_NP_RSVD};
            end
            BMW_OFF_PF_DWORD: begin
                rdata_d = {pf_high_q, BMW_PF_WIDE_FLAG, pf_low_q, BMW_PF_WIDE_FLAG};
            end
            default: begin
                rdata_d = BMW_UNMAPPED_DATA;
            end
        endcase
    end

    // reads return the value before a same-cycle write lands
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rdata <= BMW_UNMAPPED_DATA;
        end else if (i_cfg_sel && !i_cfg_we) begin
            o_cfg_rdata <= rdata_d;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_ack <= 1'b0;
        end else begin
            o_cfg_ack <= i_cfg_sel;
        end
    end

    // ============================================================
    // window compare
    logic [63:0] np_low_b;
    logic [63:0] np_high_b;
    logic [63:0] pf_low_b;
    logic [63:0] pf_high_b;
    logic np_hit;
    logic pf_hit;

    assign np_low_b = make_bound(BMW_ZERO_UPPER, np_low_q, BMW_LOW_FILL);
    assign np_high_b = make_bound(BMW_ZERO_UPPER, np_high_q, BMW_HIGH_FILL);
    assign pf_low_b = make_bound(i_pf_low_upper, pf_low_q, BMW_LOW_FILL);
    assign pf_high_b = make_bound(i_pf_high_upper, pf_high_q, BMW_HIGH_FILL);

    bmw_range_cmp #(
        .AW(BMW_ADDR_W)
    ) u_np_cmp (
        .i_addr(i_txn.addr),
        .i_low(np_low_b),
        .i_high(np_high_b),
        .o_hit(np_hit)
    );

    bmw_range_cmp #(
        .AW(BMW_ADDR_W)
    ) u_pf_cmp (
        .i_addr(i_txn.addr),
        .i_low(pf_low_b),
        .i_high(pf_high_b),
        .o_hit(pf_hit)
    );

    // one cycle of latency keeps the 64-bit compares off the output path
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_result <= '0;
        end else begin
            o_result.valid <= i_txn.valid;
            o_result.np_hit <= i_txn.valid && np_hit;
            o_result.pf_hit <= i_txn.valid && pf_hit;
            o_result.fwd_down <= i_txn.valid && (np_hit || pf_hit);
        end
    end

    // ============================================================
    // checks
    logic [31:20] a_win;
    logic a_up_zero;
    logic a_pf_in;
    assign a_win = i_txn.addr[31:20];
    assign a_up_zero = (i_txn.addr[63:32] == BMW_ZERO_UPPER);
    // pf window rebuilt from raw fields, not from the compare operands
    assign a_pf_in = (i_txn.addr >= {i_pf_low_upper, pf_low_q, BMW_LOW_FILL})
        && (i_txn.addr <= {i_pf_high_upper, pf_high_q, BMW_HIGH_FILL});

    chk_np_nibble_zero: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_sel && !i_cfg_we && i_cfg_addr == BMW_OFF_NP_DWORD)
        |=> (o_cfg_ack && o_cfg_rdata[3:0] == 4'h0 && o_cfg_rdata[19:16] == 4'h0))
        else $error("np reserved nibble not zero");

    chk_pf_wide_flag: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_cfg_sel && !i_cfg_we && i_cfg_addr == BMW_OFF_PF_DWORD)
        |=> (o_cfg_rdata[3:0] == 4'h1 && o_cfg_rdata[19:16] == 4'h1))
        else $error("pf wide flag wrong");

    chk_np_low_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_np && i_cfg_be == 4'hf) |=> (np_low_q == $past(i_cfg_wdata[15:4])))
        else $error("np lower field not written");

    chk_np_high_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_np && i_cfg_be == 4'hf) |=> (np_high_q == $past(i_cfg_wdata[31:20])))
        else $error("np upper field not written");

    chk_pf_bounds_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_pf && i_cfg_be == 4'h3) |=> (pf_low_q == $past(i_cfg_wdata[15:4]))
        && $stable(pf_high_q))
        else $error("pf lower field write wrong");

    chk_pf_high_write: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (wr_pf && i_cfg_be == 4'hc) |=> (pf_high_q == $past(i_cfg_wdata[31:20]))
        && $stable(pf_low_q))
        else $error("pf upper field write wrong");

    chk_np_below_low: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_txn.valid && a_win < np_low_q) |=> !o_result.np_hit)
        else $error("np hit below lower bound");

    chk_np_above_high: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_txn.valid && (a_win > np_high_q || !a_up_zero)) |=> !o_result.np_hit)
        else $error("np hit above upper bound");

    chk_np_inside_hit: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_txn.valid && a_up_zero && a_win >= np_low_q && a_win <= np_high_q)
        |=> (o_result.np_hit && o_result.fwd_down))
        else $error("np inside address not forwarded");

    chk_pf_window_hit: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_txn.valid |=> (o_result.pf_hit == $past(a_pf_in)))
        else $error("pf hit disagrees with window");

    chk_empty_window: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (np_low_q > np_high_q) |=> !o_result.np_hit)
        else $error("inverted np window matched");

    chk_idle_quiet: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        !i_txn.valid |=> (!o_result.valid && !o_result.fwd_down))
        else $error("result without transaction");

    chk_pf_empty_window: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_txn.valid && {i_pf_low_upper, pf_low_q} > {i_pf_high_upper, pf_high_q})
        |=> !o_result.pf_hit)
        else $error("inverted pf window matched");

    chk_cfg_ack_pulse: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        1'b1 |=> (o_cfg_ack == $past(i_cfg_sel)))
        else $error("config ack not one cycle after request");

    chk_fwd_is_union: assert property (
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        i_txn.valid |=> (o_result.fwd_down == (o_result.np_hit || o_result.pf_hit)))
        else $error("forward flag disagrees with window hits");

endmodule : bmw_window_decode
`default_nettype wire

// File: inc/bmw_pkg.sv
// ============================================================
// shared constants and carriers for the memory window decode
package bmw_pkg;

    // ============================================================
    // configuration dword offsets (byte addresses)
    localparam logic [7:0] BMW_OFF_NP_DWORD = 8'h20;
    localparam logic [7:0] BMW_OFF_NP_TOP = 8'h22;
    localparam logic [7:0] BMW_OFF_PF_DWORD = 8'h24;
    localparam logic [7:0] BMW_OFF_PF_TOP = 8'h26;

    // ============================================================
    // field layout
    localparam int BMW_FIELD_LSB = 4;
    localparam int BMW_FIELD_W = 12;
    localparam int BMW_WIN_SHIFT = 20;
    localparam int BMW_HALF_W = 16;
    localparam int BMW_UPPER_W = 32;
    localparam int BMW_ADDR_W = 64;
    localparam int BMW_TOP_LANE = 2;

    // ============================================================
    // reset values and read-only nibbles
    localparam logic [3:0] BMW_NP_RSVD = 4'h0;
    localparam logic [3:0] BMW_PF_WIDE_FLAG = 4'h1;
    localparam logic [11:0] BMW_FIELD_RST = 12'h000;
    localparam logic [19:0] BMW_LOW_FILL = 20'h00000;
    localparam logic [19:0] BMW_HIGH_FILL = 20'hfffff;
    localparam logic [31:0] BMW_ZERO_UPPER = 32'h00000000;
    localparam logic [31:0] BMW_UNMAPPED_DATA = 32'h00000000;

    // ============================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic [63:0] addr;
    } bmw_txn_t;

    typedef struct packed {
        logic valid;
        logic np_hit;
        logic pf_hit;
        logic fwd_down;
    } bmw_result_t;

endpackage : bmw_pkg

// File: verilog/bmw_range_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// inclusive range compare; an inverted range never matches
module bmw_range_cmp #(
    parameter int AW = 64
) (
    // operands
    input wire logic [AW-1:0] i_addr,
    input wire logic [AW-1:0] i_low,
    input wire logic [AW-1:0] i_high,
    // result
    output logic o_hit
);
    assign o_hit = (i_low <= i_high) && (i_addr >= i_low) && (i_addr <= i_high);
endmodule : bmw_range_cmp
`default_nettype wire

// File: testbench/bmw_upper_model.sv
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// far side: upper-half registers of the pf window
module bmw_upper_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // load port
    input wire logic i_load,
    input wire logic [31:0] i_low_data,
    input wire logic [31:0] i_high_data,
    // upper halves
    output logic [31:0] o_low_upper,
    output logic [31:0] o_high_upper
);
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_low_upper <= 32'h00000000;
            o_high_upper <= 32'h00000000;
        end else if (i_load) begin
            o_low_upper <= i_low_data;
            o_high_upper <= i_high_data;
        end
    end
endmodule : bmw_upper_model
`default_nettype wire

// File: testbench/tb_bridge_memory_window_decode.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module tb_bridge_memory_window_decode;
    import bmw_pkg::*;
    localparam logic [11:0] PF_RST = 12'h000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b0, we = 1'b0, load = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [3:0] be = 4'h0;
    logic [31:0] wd = 32'h0, ld_lo = 32'h0, ld_hi = 32'h0, up_lo, up_hi, r, rdata;
    logic ack;
    bmw_txn_t txn = '0;
    bmw_result_t res;
    logic [11:0] f_npl, f_nph, f_pfl, f_pfh;
    logic [11:0] s_npl = 12'h000, s_nph = 12'h000, s_pfl = PF_RST, s_pfh = 12'h000;
    logic [31:0] s_ulo = 32'h0, s_uhi = 32'h0;
    logic [32:0] ack_q[$];
    bmw_result_t res_q[$];
    int fail_count = 0;
    int num_checks = 0;

    bmw_window_decode #(.PF_LOW_RST(PF_RST)) dut (.i_ref_clk(clk), .i_rst_n(rst_n),
        .i_cfg_sel(sel), .i_cfg_we(we), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd),
        .o_cfg_ack(ack), .o_cfg_rdata(rdata), .i_pf_low_upper(up_lo), .i_pf_high_upper(up_hi),
        .i_txn(txn), .o_result(res), .o_np_window_low_field(f_npl),
        .o_np_window_high_field(f_nph), .o_pf_window_low_field(f_pfl),
        .o_pf_window_high_field(f_pfh));
    bmw_upper_model partner (.i_ref_clk(clk), .i_rst_n(rst_n), .i_load(load),
        .i_low_data(ld_lo), .i_high_data(ld_hi), .o_low_upper(up_lo), .o_high_upper(up_hi));

    initial begin
        forever #20 clk = ~clk;
    end

    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    // only enabled lanes land; low nibbles of each half are not storage
    task automatic lanes(input logic [3:0] b, input logic [31:0] d,
                         inout logic [11:0] lo, inout logic [11:0] hi);
        if (b[0]) lo[3:0] = d[7:4];
        if (b[1]) lo[11:4] = d[15:8];
        if (b[2]) hi[3:0] = d[23:20];
        if (b[3]) hi[11:4] = d[31:24];
    endtask : lanes

    task automatic cfg(input logic w, input logic [7:0] a, input logic [3:0] b,
                       input logic [31:0] d);
        logic [31:0] e;
        @(posedge clk);
        sel <= 1'b1;
        we <= w;
        addr <= a;
        be <= b;
        wd <= d;
        e = 32'h00000000;
        if (a == BMW_OFF_NP_DWORD) e = {s_nph, 4'h0, s_npl, 4'h0};
        if (a == BMW_OFF_PF_DWORD) e = {s_pfh, 4'h1, s_pfl, 4'h1};
        ack_q.push_back({!w, e});
        if (w && a == BMW_OFF_NP_DWORD) lanes(b, d, s_npl, s_nph);
        if (w && a == BMW_OFF_PF_DWORD) lanes(b, d, s_pfl, s_pfh);
    endtask : cfg

    task automatic dec(input logic [63:0] a);
        bmw_result_t e;
        @(posedge clk);
        txn <= '{valid: 1'b1, addr: a};
        e.valid = 1'b1;
        e.np_hit = a[63:32] == 32'h0 && a[31:0] >= {s_npl, 20'h00000}
                   && a[31:0] <= {s_nph, 20'hfffff};
        e.pf_hit = a >= {s_ulo, s_pfl, 20'h00000} && a <= {s_uhi, s_pfh, 20'hfffff};
        e.fwd_down = e.np_hit | e.pf_hit;
        res_q.push_back(e);
    endtask : dec

    task automatic idle();
        @(posedge clk);
        sel <= 1'b0;
        txn <= '0;
        load <= 1'b0;
        @(negedge clk);
        `CHK({f_npl, f_nph, f_pfl, f_pfh}, {s_npl, s_nph, s_pfl, s_pfh})
    endtask : idle

    // ============================================================
    // monitor: each answer takes the oldest note
    always @(negedge clk) begin : mon
        logic [32:0] n;
        bmw_result_t e;
        if (rst_n && ack === 1'b1) begin
            if (ack_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                n = ack_q.pop_front();
                if (n[32]) `CHK(rdata, n[31:0])
            end
        end
        if (rst_n && res.valid === 1'b1) begin
            if (res_q.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                e = res_q.pop_front();
                `CHK(res, e)
            end
        end
    end

    initial begin
        #(40 * 8000);
        fail_count++;
        conclude();
    end

    // ============================================================
    // main sequence
    initial begin
        void'($urandom(32'h3a46));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cfg(1'b0, 8'h20, 4'hf, 32'h0);
        cfg(1'b0, 8'h24, 4'hf, 32'h0);
        cfg(1'b1, 8'h20, 4'hf, 32'hffffffff);
        cfg(1'b0, 8'h20, 4'hf, 32'h0);
        cfg(1'b1, 8'h28, 4'hf, 32'hffffffff);
        cfg(1'b0, 8'h28, 4'hf, 32'h0);
        cfg(1'b0, 8'h20, 4'hf, 32'h0);
        idle();
        // every lane mix on both dwords
        for (int i = 0; i < 32; i++) begin
            cfg(1'b1, i[4] ? 8'h24 : 8'h20, i[3:0], $urandom);
            cfg(1'b0, i[4] ? 8'h24 : 8'h20, 4'hf, 32'h0);
        end
        idle();
        // random windows, often inverted, probed at their edges
        for (int i = 0; i < 40; i++) begin
            r = $urandom % 4;
            @(posedge clk);
            s_ulo = r;
            s_uhi = r + ($urandom % 2);
            load <= 1'b1;
            ld_lo <= s_ulo;
            ld_hi <= s_uhi;
            cfg(1'b1, 8'h20, 4'hf, $urandom);
            cfg(1'b1, 8'h24, 4'hf, $urandom);
            idle();
            dec({32'h0, s_npl, 20'h00000} - 64'h1);
            dec({32'h0, s_npl, 20'h00000});
            dec({32'h0, s_nph, 20'hfffff});
            dec({32'h0, s_nph, 20'hfffff} + 64'h1);
            dec({s_ulo, s_npl, 20'h00000});
            dec({s_ulo, s_pfl, 20'h00000} - 64'h1);
            dec({s_ulo, s_pfl, 20'h00000});
            dec({s_uhi, s_pfh, 20'hfffff});
            dec({s_uhi, s_pfh, 20'hfffff} + 64'h1);
            dec({30'h0, r[1:0], $urandom});
            idle();
        end
        repeat (4) @(posedge clk);
        `CHK(ack_q.size(), 0)
        `CHK(res_q.size(), 0)
        conclude();
    end
endmodule : tb_bridge_memory_window_decode
`default_nettype wire
